// *** src/bldcc_cfg.svh ***
// Purpose: Timing constants for the commutation controller
// Assumes: core clock of 100 MHz
// Notes:   The tach count is derived from a time in its own unit; other counts are given directly
`ifndef BLDCC_CFG_SVH
`define BLDCC_CFG_SVH
`define BLDCC_CLK_MHZ        100
`define BLDCC_TACH_US        113
`define BLDCC_TACH_CYCLES    (`BLDCC_TACH_US * `BLDCC_CLK_MHZ)
`define BLDCC_OSC_DIV        5000
`define BLDCC_DUTY_W         8
`define BLDCC_RAMP_DIV       64
`endif

// *** src/bldcc_pkg.sv ***
// Purpose: Types shared by the commutation controller
// Assumes: nothing
// Notes:   Phase drive is a pair of enables per leg
package bldcc_pkg;
  typedef enum logic [1:0] {BLDCC_HIZ, BLDCC_SRC, BLDCC_SNK} bldcc_leg_type;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bldcc_drive_type;
  typedef struct packed {
    logic coast;
    logic brake;
    logic overCurrent;
    logic underVoltage;
    logic rampLow;
  } bldcc_fault_type;
endpackage

// *** src/bldcc_tach.sv ***
// Purpose: Speed pulse one-shot on Hall edges with position latch
// Assumes: Hall inputs already synchronised
// Notes:   Latch frozen while pulse is high
`timescale 1ns/1ps
`default_nettype none
`include "bldcc_cfg.svh"
module bldcc_tach
  import bldcc_pkg::*;
#(
  parameter int WIDTH = `BLDCC_TACH_CYCLES
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] hallIn,
  output logic      [2:0] hallPos,
  output logic            tachPulse
);
  typedef struct packed {
    logic [2:0]  pos;
    logic        pulse;
    logic [31:0] cnt;
  } bldcc_tach_st_type;
  bldcc_tach_st_type st;
  bldcc_tach_st_type next_st;

  always_comb
  begin
    next_st = st;
    if (st.pulse)
    begin
      if (st.cnt == 32'h0000_0001)
        next_st.pulse = 1'b0;
      next_st.cnt = st.cnt - 32'h0000_0001;
    end
    else if (hallIn != st.pos)
    begin
      next_st.pos = hallIn;
      next_st.pulse = 1'b1;
      next_st.cnt = 32'(WIDTH);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign hallPos = st.pos;
  assign tachPulse = st.pulse;
endmodule
`default_nettype wire

// *** src/bldcc_dir.sv ***
// Purpose: Direction latch, two-stage shift and mismatch inhibit
// Assumes: oscTick is a one-cycle pulse per PWM period
// Notes:   Inhibit covers the dead time on reversal
`timescale 1ns/1ps
`default_nettype none
module bldcc_dir
  import bldcc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic dirIn,
  input  wire logic speedAbove,
  input  wire logic oscTick,
  output logic      dirOut,
  output logic      dirInhibit
);
  typedef struct packed {
    logic latch;
    logic [1:0] shift;
  } bldcc_dir_st_type;
  bldcc_dir_st_type st;
  bldcc_dir_st_type next_st;

  always_comb
  begin
    next_st = st;
    if (!speedAbove)
      next_st.latch = dirIn;
    if (oscTick)
      next_st.shift = {st.shift[0], st.latch};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign dirOut = st.shift[1];
  assign dirInhibit = (dirIn != st.latch) || (st.latch != st.shift[0])
                      || (st.shift[0] != st.shift[1]);
endmodule
`default_nettype wire

// *** src/bldcc_top.sv ***
// Purpose: Commutation, chopping and protection for a 3-phase motor drive
// Assumes: Analog comparator results arrive as logic levels
// Notes:   Phase legs driven by high/low enables; all outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "bldcc_cfg.svh"

module bldcc_top
  import bldcc_pkg::*;
#(
  parameter int TACH_CYCLES = `BLDCC_TACH_CYCLES,
  parameter int OSC_DIV     = `BLDCC_OSC_DIV,
  parameter int RAMP_DIV    = `BLDCC_RAMP_DIV
)
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic [2:0]               positionSensor,
  input  wire logic                     direction,
  input  wire logic                     speedAbove,
  input  wire logic                     quadSelect,
  input  wire logic                     brakeRequest,
  input  wire logic                     coastRequest,
  input  wire logic                     underVoltage,
  input  wire logic                     overCurrent,
  input  wire logic                     peakCurrentTrip,
  input  wire logic [`BLDCC_DUTY_W-1:0] loopAmplifier,
  output logic      [2:0]               highDrive,
  output logic      [2:0]               lowDrive,
  output logic                          speedPulse,
  output logic                          softStartLatched,
  output logic      [`BLDCC_DUTY_W-1:0] softStartRamp
);
  localparam int DW = `BLDCC_DUTY_W;

  // Block state outside uTach and uDir; one comb process builds next_st, one flop stores it
  typedef struct packed {
    logic [2:0]    hallS1;
    logic [2:0]    hallS2;
    logic          dirS1;
    logic          dirS2;
    logic [31:0]   oscCnt;
    logic [DW-1:0] phase;
    logic          pwmOn;
    logic [31:0]   rampCnt;
    logic [DW-1:0] ramp;
    logic          ssLatch;
    logic [2:0]    high;
    logic [2:0]    low;
    logic          tach;
  } bldcc_top_st_type;
  bldcc_top_st_type st;
  bldcc_top_st_type next_st;

  logic [2:0] hallPos;
  logic       tachPulse;
  logic       dirOut;
  logic       dirInhibit;
  logic       oscTick;
  logic       forceOff;

  // One-cycle enable per PWM period; the direction shift and the PWM latch
  // both step on it, which gives the reversal dead time its 1-2 period span
  assign oscTick = (st.oscCnt == 32'(OSC_DIV - 1));

  // Coast, the soft-start latch, direction inhibit or overcurrent floats all six switches, ahead of brake; peak trip only chops
  assign forceOff = coastRequest || st.ssLatch || dirInhibit || overCurrent;

  // Six-step decode of one leg
  function automatic bldcc_leg_type legState(input logic dir, input logic [2:0] h,
                                             input int leg);
    bldcc_leg_type a;
    bldcc_leg_type b;
    bldcc_leg_type c;
    a = BLDCC_HIZ;
    b = BLDCC_HIZ;
    c = BLDCC_HIZ;
    // Index is {direction, sensor 1, sensor 2, sensor 3}
    unique case ({dir, h})
      4'h9:
      begin
        b = BLDCC_SNK;
        c = BLDCC_SRC;
      end
      4'hb:
      begin
        a = BLDCC_SNK;
        c = BLDCC_SRC;
      end
      4'ha:
      begin
        a = BLDCC_SNK;
        b = BLDCC_SRC;
      end
      4'he:
      begin
        b = BLDCC_SRC;
        c = BLDCC_SNK;
      end
      4'hc:
      begin
        a = BLDCC_SRC;
        c = BLDCC_SNK;
      end
      4'hd:
      begin
        a = BLDCC_SRC;
        b = BLDCC_SNK;
      end
      4'h5:
      begin
        a = BLDCC_SNK;
        b = BLDCC_SRC;
      end
      4'h4:
      begin
        a = BLDCC_SNK;
        c = BLDCC_SRC;
      end
      4'h6:
      begin
        b = BLDCC_SNK;
        c = BLDCC_SRC;
      end
      4'h2:
      begin
        a = BLDCC_SRC;
        b = BLDCC_SNK;
      end
      4'h3:
      begin
        a = BLDCC_SRC;
        c = BLDCC_SNK;
      end
      4'h1:
      begin
        b = BLDCC_SRC;
        c = BLDCC_SNK;
      end
      // All-low, all-high and unused codes leave every leg floating
      default:
      begin
        a = BLDCC_HIZ;
      end
    endcase
    if (leg == 0)
      return a;
    else if (leg == 1)
      return b;
    return c;
  endfunction

  // Hall latch reads the synchronised sensors and freezes during its pulse
  bldcc_tach #(
    .WIDTH(TACH_CYCLES)
  ) uTach (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .hallIn   (st.hallS2),
    .hallPos  (hallPos),
    .tachPulse(tachPulse)
  );

  // Speed compare is a level; the direction pin arrives synchronised
  bldcc_dir uDir (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .dirIn     (st.dirS2),
    .speedAbove(speedAbove),
    .oscTick   (oscTick),
    .dirOut    (dirOut),
    .dirInhibit(dirInhibit)
  );

  always_comb
  begin
    logic [DW-1:0] duty;
    logic          chop;
    bldcc_leg_type leg;
    duty = '0;
    chop = 1'b0;
    leg = BLDCC_HIZ;
    next_st = st;
    // input synchronisers
    // Only the second stage of each pair is read downstream
    next_st.hallS1 = positionSensor;
    next_st.hallS2 = st.hallS1;
    next_st.dirS1 = direction;
    next_st.dirS2 = st.dirS1;
    next_st.tach = tachPulse;

    // PWM oscillator and ramp carrier
    next_st.oscCnt = oscTick ? 32'h0 : st.oscCnt + 32'h1;
    // Phase tracks the count the next cycle holds, so a tick starts at zero
    next_st.phase = DW'((next_st.oscCnt * (2 ** DW)) / OSC_DIV);

    if (underVoltage || overCurrent)
      next_st.ssLatch = 1'b1;
    else if (st.ssLatch && st.ramp == '0)
      next_st.ssLatch = 1'b0;

    // Ramp parks at zero while latched and climbs one step per RAMP_DIV cycles
    if (st.ssLatch)
    begin
      next_st.ramp = '0;
      next_st.rampCnt = '0;
    end
    else if (st.ramp != '1)
    begin
      if (st.rampCnt == 32'(RAMP_DIV - 1))
      begin
        next_st.rampCnt = '0;
        next_st.ramp = st.ramp + 1'b1;
      end
      else
        next_st.rampCnt = st.rampCnt + 32'h1;
    end

    // duty clamp to ramp
    // The ramp caps the loop command until it has climbed past it
    duty = (st.ramp < loopAmplifier) ? st.ramp : loopAmplifier;

    if (oscTick)
      next_st.pwmOn = 1'b1;
    else if (peakCurrentTrip || st.phase >= duty)
      next_st.pwmOn = 1'b0;
    // Trip or crossing ends the on time; only the next tick restarts it
    chop = !st.pwmOn;

    if (forceOff)
    begin
      next_st.high = '0;
      next_st.low = '0;
    end
    // brake pattern
    // Windings shorted through the low side, so chopping has no role here
    else if (brakeRequest)
    begin
      next_st.high = '0;
      next_st.low = '1;
    end
    else
    begin
      // Each leg sources, sinks or floats, then the chop phase gates the sink side, and the source side too when quadSelect is set
      for (int i = 0; i < 3; i++)
      begin
        leg = legState(dirOut, hallPos, i);
        next_st.high[i] = (leg == BLDCC_SRC) && !(quadSelect && chop);
        next_st.low[i] = (leg == BLDCC_SNK) && !chop;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      // Start latched so the first run ramps up from zero
      st.ssLatch <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Every output comes straight from a state flop
  assign highDrive = st.high;
  assign lowDrive = st.low;
  assign speedPulse = st.tach;
  assign softStartLatched = st.ssLatch;
  assign softStartRamp = st.ramp;
endmodule
`default_nettype wire

// *** tb/bldcc_hall_model.sv ***
// Purpose: Hall sensor model stepping the six-step Gray sequence
// Assumes: step 6 and 7 select the two illegal codes
// Notes:   Output changes just after the clock edge
`timescale 1ns/1ps
`default_nettype none
module bldcc_hall_model
(
  input  wire logic       core_clk,
  input  wire logic [2:0] step,
  output logic      [2:0] hall
);
  logic [2:0] codes [8] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h0, 3'h7};
  // Only one sensor changes between neighbouring steps of the six-step sequence, steps 0 to 5
  always_ff @(posedge core_clk)
  begin
    hall <= codes[step];
  end
endmodule
`default_nettype wire

// *** tb/bldcc_top_properties.sv ***
// Purpose: Port checks for the commutation controller
// Assumes: bound to bldcc_top
// Notes:   Drives lag control inputs by one edge
`timescale 1ns/1ps
`default_nettype none
module bldcc_props
#(
  parameter int TACH_CYCLES = 20
)
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] positionSensor,
  input wire logic       brakeRequest,
  input wire logic       coastRequest,
  input wire logic       underVoltage,
  input wire logic       overCurrent,
  input wire logic [2:0] highDrive,
  input wire logic [2:0] lowDrive,
  input wire logic       speedPulse,
  input wire logic       softStartLatched,
  input wire logic [7:0] softStartRamp
);
  int   pulseLen;
  logic offAll;
  assign offAll = highDrive == 3'h0 && lowDrive == 3'h0;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !speedPulse)
      pulseLen <= 0;
    else
      pulseLen <= pulseLen + 1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_badHall;
    ((positionSensor == 3'h0 || positionSensor == 3'h7) && !speedPulse) [*8];
  endsequence
  sequence s_hallStep;
    $changed(positionSensor) && !speedPulse;
  endsequence
  a_coast_hiz: assert property (coastRequest && $past(coastRequest) |-> offAll)
    else $error("coast left a leg driven");
  a_brake_highs: assert property (brakeRequest && $past(brakeRequest) |-> highDrive == 3'h0)
    else $error("high side on during brake");
  a_tach_start: assert property (s_hallStep |-> ##[1:5] speedPulse)
    else $error("no speed pulse after hall change");
  a_tach_width: assert property ($fell(speedPulse) |-> pulseLen == TACH_CYCLES)
    else $error("speed pulse width wrong");
  a_tach_max: assert property (pulseLen <= TACH_CYCLES)
    else $error("speed pulse too long");
  a_bad_hall: assert property (s_badHall |-> offAll)
    else $error("illegal hall code drove a leg");
  a_no_overlap: assert property ((highDrive & lowDrive) == 3'h0)
    else $error("both switches of a leg on");
  a_fault_set: assert property ($past(underVoltage || overCurrent) |-> softStartLatched)
    else $error("fault did not set soft-start latch");
  a_latch_off: assert property (softStartLatched && $past(softStartLatched) |-> offAll)
    else $error("legs driven while latched");
  a_ramp_clear: assert property ($fell(softStartLatched) |-> $past(softStartRamp) == 8'h00)
    else $error("latch cleared with ramp not low");
endmodule
`default_nettype wire

// *** tb/bldcc_top_tb.sv ***
// Purpose: Self-checking bench for the commutation controller
// Assumes: short counts TACH_CYCLES 20, OSC_DIV 16, RAMP_DIV 1
// Notes:   Inputs change on rising edges, outputs read on falling edges
`timescale 1ns/1ps
`default_nettype none
module bldcc_top_tb;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] step = 3'h0;
  logic [2:0] positionSensor;
  logic       direction = 1'b1;
  logic       speedAbove = 1'b0;
  logic       quadSelect = 1'b0;
  logic       brakeRequest = 1'b0;
  logic       coastRequest = 1'b0;
  logic       underVoltage = 1'b0;
  logic       overCurrent = 1'b0;
  logic       peakCurrentTrip = 1'b0;
  logic [7:0] loopAmplifier = 8'hff;
  logic [2:0] highDrive;
  logic [2:0] lowDrive;
  logic       speedPulse;
  logic       softStartLatched;
  logic [7:0] softStartRamp;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  // Expected enables for direction 1; direction 0 swaps high and low
  localparam logic [2:0] HI1 [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
  localparam logic [2:0] LO1 [6] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
  bldcc_top #(.TACH_CYCLES(20), .OSC_DIV(16), .RAMP_DIV(1)) bldcc_top_inst (.core_clk, .rst_n,
    .positionSensor, .direction, .speedAbove, .quadSelect, .brakeRequest, .coastRequest,
    .underVoltage, .overCurrent, .peakCurrentTrip, .loopAmplifier, .highDrive, .lowDrive,
    .speedPulse, .softStartLatched, .softStartRamp);
  bldcc_hall_model bldcc_hall_model_inst (.core_clk, .step, .hall(positionSensor));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic drv(logic [2:0] h, logic [2:0] l);
    chk("highDrive", highDrive, h);
    chk("lowDrive", lowDrive, l);
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 600 && softStartRamp !== 8'hff; i++) cyc(1);
    chk("latch", softStartLatched, 8'h00);
    chk("ramp", softStartRamp, 8'hff);
  endtask
  task automatic t_steps(logic d);
    int s;
    for (s = 0; s < 8; s++)
    begin
      @(posedge core_clk);
      step <= s[2:0];
      cyc(30);
      if (s > 5) drv(3'h0, 3'h0);
      else if (d) drv(HI1[s], LO1[s]);
      else drv(LO1[s], HI1[s]);
    end
    @(posedge core_clk);
    step <= 3'h0;
    cyc(30);
    $display("test steps done");
  endtask
  task automatic t_dir();
    @(posedge core_clk);
    speedAbove <= 1'b1;
    direction <= 1'b0;
    cyc(60);
    drv(3'h0, 3'h0);
    @(posedge core_clk);
    direction <= 1'b1;
    cyc(10);
    drv(HI1[0], LO1[0]);
    @(posedge core_clk);
    speedAbove <= 1'b0;
    direction <= 1'b0;
    cyc(6);
    drv(3'h0, 3'h0);
    cyc(60);
    drv(LO1[0], HI1[0]);
    $display("test direction done");
  endtask
  task automatic t_tach();
    int i;
    int n;
    @(posedge core_clk);
    step <= 3'h5;
    cyc(30);
    @(posedge core_clk);
    step <= 3'h0;
    for (i = 0; i < 10 && speedPulse !== 1'b1; i++) cyc(1);
    fork
      for (n = 0; n < 40 && speedPulse === 1'b1; n++) cyc(1);
      begin
        @(posedge core_clk);
        step <= 3'h1;
        cyc(8);
        drv(LO1[0], HI1[0]);
      end
    join
    chk("pulseWidth", n[7:0], 8'h14);
    cyc(30);
    drv(LO1[1], HI1[1]);
    $display("test tach done");
  endtask
  task automatic t_brake();
    @(posedge core_clk);
    brakeRequest <= 1'b1;
    cyc(4);
    drv(3'h0, 3'h7);
    @(posedge core_clk);
    quadSelect <= 1'b1;
    cyc(4);
    drv(3'h0, 3'h7);
    @(posedge core_clk);
    coastRequest <= 1'b1;
    cyc(4);
    drv(3'h0, 3'h0);
    @(posedge core_clk);
    brakeRequest <= 1'b0;
    coastRequest <= 1'b0;
    quadSelect <= 1'b0;
    cyc(4);
    $display("test brake done");
  endtask
  task automatic t_chop();
    int c, i, hiT, loT, onCnt;
    logic [2:0] lastHi, lastLo;
    for (c = 0; c < 3; c++)
    begin
      @(posedge core_clk);
      quadSelect <= c != 0;
      peakCurrentTrip <= c == 2;
      loopAmplifier <= (c == 2) ? 8'hff : 8'h08;
      cyc(20);
      hiT = 0;
      loT = 0;
      onCnt = 0;
      for (i = 0; i < 48; i++)
      begin
        lastHi = highDrive;
        lastLo = lowDrive;
        cyc(1);
        hiT += highDrive != lastHi;
        loT += lowDrive != lastLo;
        onCnt += lowDrive != 3'h0;
      end
      if (c < 2) chk("highChop", hiT != 0, c[0]);
      if (c < 2) chk("lowChop", loT != 0, 8'h01);
      else chk("tripOff", onCnt < 4, 8'h01);
    end
    @(posedge core_clk);
    quadSelect <= 1'b0;
    peakCurrentTrip <= 1'b0;
    loopAmplifier <= 8'hff;
    cyc(4);
    $display("test chop done");
  endtask
  task automatic t_fault();
    int f, i, onCnt;
    for (f = 0; f < 2; f++)
    begin
      @(posedge core_clk);
      underVoltage <= f == 0;
      overCurrent <= f == 1;
      cyc(3);
      chk("latch", softStartLatched, 8'h01);
      drv(3'h0, 3'h0);
      @(posedge core_clk);
      underVoltage <= 1'b0;
      overCurrent <= 1'b0;
      onCnt = 0;
      for (i = 0; i < 24; i++)
      begin
        cyc(1);
        onCnt += (i >= 8) && lowDrive != 3'h0;
      end
      chk("rampClamp", onCnt < 4, 8'h01);
      settle();
    end
    $display("test fault done");
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    t_steps(1'b1);
    t_dir();
    t_steps(1'b0);
    t_tach();
    t_brake();
    t_chop();
    t_fault();
    results();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
bind bldcc_top bldcc_props #(.TACH_CYCLES(TACH_CYCLES)) bldcc_props_inst (.core_clk, .rst_n,
  .positionSensor, .brakeRequest, .coastRequest, .underVoltage, .overCurrent, .highDrive,
  .lowDrive, .speedPulse, .softStartLatched, .softStartRamp);
`default_nettype wire
